// File: common/gch_pkg.sv
// Shared constants and helpers for the graphics configuration header block
package gch_pkg;

  // ***************************************************************
  // Configuration space byte offsets
  // ***************************************************************
  localparam logic [7:0] HDR_TYPE_OFS   = 8'h0e;  // Header type byte
  localparam logic [7:0] MMIO_BASE_OFS  = 8'h10;  // Combined register/table base, low dword
  localparam logic [7:0] MMIO_BASE_OFS_HI = 8'h14; // Combined base, high dword
  localparam logic [7:0] APER_BASE_OFS  = 8'h18;  // Aperture base, low dword
  localparam logic [7:0] APER_BASE_OFS_HI = 8'h1c; // Aperture base, high dword
  localparam logic [7:0] IO_BASE_OFS    = 8'h20;  // I/O window base
  localparam logic [7:0] SVID_OFS       = 8'h2c;  // Subsystem vendor code

  // ***************************************************************
  // Field layout and fixed values
  // ***************************************************************
  localparam int         HDR_TYPE_LSB   = 16;     // Header byte lane in its dword
  localparam logic [6:0] HDR_CODE       = 7'h00;  // Type 0 layout code
  localparam logic [7:0] HDR_TYPE_RST   = 8'h80;  // Reset view with function 1 on
  localparam logic [31:0] MMIO_WMASK_LO = 32'hffc0_0000; // Base bits 31:22
  localparam logic [31:0] MMIO_FIXED_LO = 32'h0000_0004; // 64-bit, not prefetchable
  localparam logic [31:0] HI_WMASK      = 32'hffff_ffff; // Bits 63:32 all writable
  localparam logic [31:0] APER_WMASK_LO = 32'he000_0000; // Base bits 31:29
  localparam logic [31:0] APER_BIT28    = 32'h1000_0000; // 512 MB mask bit
  localparam logic [31:0] APER_BIT27    = 32'h0800_0000; // 256 MB mask bit
  localparam logic [31:0] APER_FIXED_LO = 32'h0000_000c; // 64-bit, prefetchable
  localparam logic [31:0] IO_WMASK      = 32'h0000_fff8; // Base bits 15:3
  localparam logic [31:0] IO_FIXED      = 32'h0000_0001; // I/O space indicator
  localparam logic [63:0] MMIO_RST      = 64'h0000_0000_0000_0004;
  localparam logic [63:0] APER_RST      = 64'h0000_0000_0000_0000;
  localparam logic [31:0] IO_RST        = 32'h0000_0001;
  localparam int          SVID_W        = 16;     // Subsystem vendor code width
  localparam logic [15:0] SVID_RST      = 16'h0000;

  // ***************************************************************
  // Decode geometry
  // ***************************************************************
  localparam int          MEM_AW        = 36;     // Memory address width
  localparam int          IO_AW         = 16;     // I/O address width
  localparam int          IO_WIN_LSB    = 3;      // 8-byte I/O window
  localparam logic [35:0] MMIO_WIN_MASK = 36'hf_ffc0_0000; // 4 MB window
  localparam logic [35:0] REGS_MASK     = 36'hf_fff8_0000; // 512 KB register space
  localparam logic [35:0] TABLE_MASK    = 36'hf_ffe0_0000; // 2 MB table
  localparam logic [35:0] TABLE_OFFSET  = 36'h0_0020_0000; // Table sits at base + 2 MB
  localparam logic [1:0]  PM_D0         = 2'b00;  // Full-power state code

  // Merge write data into a register under byte enables and a writable mask
  function automatic logic [31:0] apply_write(input logic [31:0] old_val,
                                              input logic [31:0] wdata,
                                              input logic [3:0]  be,
                                              input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_val & ~m) | (wdata & m);
  endfunction

  // Address matches base on every bit the mask keeps
  function automatic logic addr_match(input logic [35:0] addr,
                                      input logic [35:0] base,
                                      input logic [35:0] mask);
    return ((addr ^ base) & mask) == 36'h0;
  endfunction

endpackage

// File: rtl/gch_write_once.sv
// Write-once register that locks after its first accepted write
`timescale 1ns/10ps
`default_nettype none
module gch_write_once
  import gch_pkg::*;
#(
  parameter int W = 16  // Register width, whole bytes
) (
  input  wire logic           mclk,   // System clock
  input  wire logic           reset,  // Async reset, active high
  input  wire logic           wr_en,  // Write strobe for this register
  input  wire logic [W/8-1:0] wr_be,  // Byte enables
  input  wire logic [W-1:0]   wr_data, // Write data
  output logic      [W-1:0]   value,  // Stored value
  output logic                locked  // High once written
);

  // Byte enables map to whole lanes only, so a ragged width is refused
  if (W % 8 != 0 || W < 8) begin
    $error("gch_write_once: W must be whole bytes");
  end

  // ***************************************************************
  // Storage and lock
  // ***************************************************************
  // Only reset clears the lock, so software cannot reopen the field
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      value  <= W'(SVID_RST);
      locked <= 1'b0;
    end else if (wr_en && !locked && |wr_be) begin
      for (int i = 0; i < W / 8; i++) begin
        if (wr_be[i]) begin
          value[i*8 +: 8] <= wr_data[i*8 +: 8];
        end
      end
      locked <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// File: rtl/gch_io_window.sv
// Eight-byte I/O window decode with power and enable gating
`timescale 1ns/10ps
`default_nettype none
module gch_io_window
  import gch_pkg::*;
#(
  parameter int AW = IO_AW  // I/O address width
) (
  input  wire logic                 mclk,            // System clock
  input  wire logic                 reset,           // Async reset, active high
  input  wire logic                 io_req,          // I/O access strobe
  input  wire logic [AW-1:0]        io_addr,         // I/O address
  input  wire logic [AW-1:IO_WIN_LSB] io_base,       // Programmed window base
  input  wire logic [1:0]           pm_state,        // Power state, D0..D3
  input  wire logic                 io_enable,       // Command register I/O enable
  input  wire logic                 device_on,       // Device switched on
  input  wire logic                 graphics_enable, // Internal graphics enabled
  output logic                      io_hit,          // Access claimed
  output logic                      io_refused       // Access to window refused
);

  // The window needs at least one base bit above its 8-byte offset
  if (AW <= IO_WIN_LSB) begin
    $error("gch_io_window: AW too small");
  end

  logic match;    // Address falls in the window
  logic allowed;  // Gating conditions all met

  // Window decode stands on its own; legacy VGA ranges never enter it
  assign match   = io_addr[AW-1:IO_WIN_LSB] == io_base;
  assign allowed = (pm_state == PM_D0) && io_enable
                   && device_on && graphics_enable;

  // ***************************************************************
  // Registered answer
  // ***************************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      io_hit     <= 1'b0;
      io_refused <= 1'b0;
    end else begin
      io_hit     <= io_req && match && allowed;
      io_refused <= io_req && match && !allowed;
    end
  end

endmodule
`default_nettype wire

// File: rtl/gch_cfg_bars.sv
// Configuration header range with memory and I/O base registers
//
// Summary of operation
// - Multi-function bit follows function 1 enable
// - Header code bits always read zero
// - Combined base bits 35:22 writable, 4 MB
// - Registers at base, table at base+2MB
// - Combined base low bits fixed: 64-bit memory
// - Aperture base bits 35:29 writable
// - Size control makes bits 28/27 mask
// - Trusted mode freezes aperture bits 28/27
// - Aperture bits 26:4 read zero
// - Aperture reads prefetchable 64-bit memory
// - I/O base bits 15:3 writable
// - I/O base bit 0 one, 2:1 zero
// - I/O base bits 31:16 read zero
// - I/O window open in D0 with I/O, device and graphics enables
// - I/O window refused when gated off
// - I/O decode independent, function 0 only
// - Vendor code writes once, reset clears
`timescale 1ns/10ps
`default_nettype none
module gch_cfg_bars
  import gch_pkg::*;
(
  input  wire logic        mclk,                  // System clock, 50 MHz
  input  wire logic        reset,                 // Async reset, active high
  input  wire logic        cfg_req,               // Config access strobe
  input  wire logic        cfg_write,             // 1 write, 0 read
  input  wire logic [7:0]  cfg_addr,              // Config byte offset
  input  wire logic [3:0]  cfg_be,                // Byte enables
  input  wire logic [31:0] cfg_wdata,             // Write data
  output logic             cfg_ack,               // Access done
  output logic      [31:0] cfg_rdata,             // Read data
  input  wire logic        func1_enable,          // Device enable bit 4
  input  wire logic [1:0]  aperture_size_control, // Aperture size select
  input  wire logic        trusted_execution_mode, // Trusted mode active
  input  wire logic [1:0]  pm_state,              // Power state
  input  wire logic        io_enable,             // Command register bit 0
  input  wire logic        device_on,             // Device switched on
  input  wire logic        graphics_enable,       // Internal graphics on
  input  wire logic [35:0] mem_addr,              // Memory address to decode
  input  wire logic        mem_req,               // Memory access strobe
  output logic             regs_hit,              // Register space claimed
  output logic             table_hit,             // Translation table claimed
  output logic             aperture_hit,          // Aperture claimed
  input  wire logic        io_req,                // I/O access strobe
  input  wire logic [15:0] io_addr,               // I/O address
  output logic             io_hit,                // I/O window claimed
  output logic             io_refused,            // I/O window refused
  output logic             svid_locked            // Vendor code locked
);

  // ***************************************************************
  // Storage and derived views
  // ***************************************************************
  logic [31:0] mmio_lo;      // Combined base low dword, writable bits only
  logic [31:0] mmio_hi;      // Combined base high dword
  logic [31:0] aper_lo;      // Aperture base low dword, writable bits only
  logic [31:0] aper_hi;      // Aperture base high dword
  logic [31:0] io_base;      // I/O base, writable bits only
  logic [15:0] svid_value;   // Subsystem vendor code
  logic [31:0] aper_rmask;   // Aperture bits that hold base now
  logic [31:0] aper_wmask;   // Aperture bits software may write now
  logic [31:0] hdr_view;     // Dword holding the header type
  logic [31:0] mmio_view;    // Combined base low as read
  logic [31:0] aper_view;    // Aperture low as read
  logic [31:0] io_view;      // I/O base as read
  logic [35:0] mmio_base36;  // Combined window base address
  logic [35:0] aper_base36;  // Aperture base address
  logic [35:0] aper_dmask;   // Aperture decode mask
  logic [7:0]  dw;           // Dword-aligned access offset
  logic        wr;           // Write strobe
  logic        rd;           // Read strobe

  assign dw = {cfg_addr[7:2], 2'b00};
  assign wr = cfg_req && cfg_write;
  assign rd = cfg_req && !cfg_write;

  // Size control: 00 keeps both bits as base, 01 masks bit 27, 1x masks both
  assign aper_rmask = APER_WMASK_LO
                      | (aperture_size_control[1] ? 32'h0 : APER_BIT28)
                      | (aperture_size_control == 2'b00 ? APER_BIT27 : 32'h0);
  // Trusted mode keeps bits 28 and 27 frozen whatever the size setting
  assign aper_wmask = trusted_execution_mode
                      ? APER_WMASK_LO
                      : aper_rmask;

  // Read views: stored writable bits plus hardwired constants
  assign hdr_view  = {8'h00, func1_enable, HDR_CODE, 16'h0000};
  assign mmio_view = (mmio_lo & MMIO_WMASK_LO) | MMIO_FIXED_LO;
  assign aper_view = (aper_lo & aper_rmask) | APER_FIXED_LO;
  assign io_view   = (io_base & IO_WMASK) | IO_FIXED;

  // Bases hold address bits only; the type flags never enter the decode
  assign mmio_base36 = {mmio_hi[3:0], mmio_lo};
  assign aper_base36 = {aper_hi[3:0], aper_lo & aper_rmask};
  assign aper_dmask  = {4'hf, aper_rmask};

  // ***************************************************************
  // Combined register and table base
  // ***************************************************************
  // Only bits 31:22 of the low dword take data; the rest are constants
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mmio_lo <= MMIO_RST[31:0] & MMIO_WMASK_LO;
      mmio_hi <= MMIO_RST[63:32];
    end else if (wr) begin
      if (dw == MMIO_BASE_OFS) begin
        mmio_lo <= apply_write(mmio_lo, cfg_wdata, cfg_be, MMIO_WMASK_LO);
      end
      if (dw == MMIO_BASE_OFS_HI) begin
        mmio_hi <= apply_write(mmio_hi, cfg_wdata, cfg_be, HI_WMASK);
      end
    end
  end

  // ***************************************************************
  // Aperture base
  // ***************************************************************
  // A bit switched to mask keeps its old content but reads as zero
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      aper_lo <= APER_RST[31:0];
      aper_hi <= APER_RST[63:32];
    end else if (wr) begin
      if (dw == APER_BASE_OFS) begin
        aper_lo <= apply_write(aper_lo, cfg_wdata, cfg_be, aper_wmask);
      end
      if (dw == APER_BASE_OFS_HI) begin
        aper_hi <= apply_write(aper_hi, cfg_wdata, cfg_be, HI_WMASK);
      end
    end
  end

  // ***************************************************************
  // I/O window base
  // ***************************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      io_base <= IO_RST & IO_WMASK;
    end else if (wr && dw == IO_BASE_OFS) begin
      io_base <= apply_write(io_base, cfg_wdata, cfg_be, IO_WMASK);
    end
  end

  // ***************************************************************
  // Subsystem vendor code
  // ***************************************************************
  // Firmware is expected to fill this at boot; later writes are dropped
  gch_write_once #(
    .W (SVID_W)
  ) u_svid (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (wr && dw == SVID_OFS),
    .wr_be   (cfg_be[1:0]),
    .wr_data (cfg_wdata[15:0]),
    .value   (svid_value),
    .locked  (svid_locked)
  );

  // ***************************************************************
  // Configuration read path
  // ***************************************************************
  // Writes to header, hardwired bits or unmapped offsets change nothing
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= 32'h0;
    end else begin
      cfg_ack <= cfg_req;
      if (rd) begin
        unique case (dw)
          {HDR_TYPE_OFS[7:2], 2'b00}: cfg_rdata <= hdr_view;
          MMIO_BASE_OFS:    cfg_rdata <= mmio_view;
          MMIO_BASE_OFS_HI: cfg_rdata <= mmio_hi;
          APER_BASE_OFS:    cfg_rdata <= aper_view;
          APER_BASE_OFS_HI: cfg_rdata <= aper_hi;
          IO_BASE_OFS:      cfg_rdata <= io_view;
          SVID_OFS:         cfg_rdata <= {16'h0000, svid_value};
          default:          cfg_rdata <= 32'h0;
        endcase
      end else begin
        cfg_rdata <= 32'h0;  // Bus stays quiet outside reads
      end
    end
  end

  // ***************************************************************
  // Memory decode
  // ***************************************************************
  // Registered so the claim lines never glitch with the address
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      regs_hit     <= 1'b0;
      table_hit    <= 1'b0;
      aperture_hit <= 1'b0;
    end else begin
      regs_hit     <= mem_req && addr_match(mem_addr, mmio_base36, REGS_MASK);
      table_hit    <= mem_req && addr_match(mem_addr, mmio_base36 + TABLE_OFFSET,
                                            TABLE_MASK);
      aperture_hit <= mem_req && addr_match(mem_addr, aper_base36, aper_dmask);
    end
  end

  // ***************************************************************
  // I/O window, function 0 only
  // ***************************************************************
  gch_io_window #(
    .AW (IO_AW)
  ) u_io (
    .mclk            (mclk),
    .reset           (reset),
    .io_req          (io_req),
    .io_addr         (io_addr),
    .io_base         (io_base[15:3]),
    .pm_state        (pm_state),
    .io_enable       (io_enable),
    .device_on       (device_on),
    .graphics_enable (graphics_enable),
    .io_hit          (io_hit),
    .io_refused      (io_refused)
  );

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  hdr_mfunc_a: assert property (rd && dw == 8'h0c |=> cfg_rdata[23] == $past(func1_enable))
    else $error("header multi-function bit wrong");
  hdr_code_a: assert property (rd && dw == 8'h0c |=> cfg_rdata[22:16] == 7'h00)
    else $error("header code not zero");
  mmio_write_a: assert property (wr && dw == MMIO_BASE_OFS && cfg_be[3] ##1 !cfg_req
      ##1 rd && dw == MMIO_BASE_OFS
      |=> cfg_rdata[31:24] == $past(cfg_wdata[31:24], 3))
    else $error("combined base did not take write");
  mmio_fixed_a: assert property (rd && dw == MMIO_BASE_OFS |=> cfg_rdata[21:0] == 22'h4)
    else $error("combined base low bits wrong");
  table_dec_a: assert property (mem_req && mem_addr == mmio_base36 + 36'h20_0000
      |=> table_hit && !regs_hit)
    else $error("table not at base plus 2 MB");
  aper_lock_a: assert property (trusted_execution_mode && wr && dw == APER_BASE_OFS
      |=> aper_lo[28:27] == $past(aper_lo[28:27]))
    else $error("aperture bits moved in trusted mode");
  aper_mask_a: assert property (rd && dw == APER_BASE_OFS && aperture_size_control[1]
      |=> cfg_rdata[28:0] == 29'h0000_000c)
    else $error("aperture mask bits not zero");
  aper_fixed_a: assert property (rd && dw == APER_BASE_OFS |=> cfg_rdata[26:0] == 27'h000000c)
    else $error("aperture low bits wrong");
  io_fixed_a: assert property (rd && dw == IO_BASE_OFS
      |=> cfg_rdata[31:16] == 16'h0 && cfg_rdata[2:0] == 3'b001)
    else $error("I/O base fixed bits wrong");
  io_gate_a: assert property (io_req && (pm_state != PM_D0 || !io_enable) |=> !io_hit)
    else $error("I/O window open while gated");
  svid_once_a: assert property (svid_locked |=> $stable(svid_value))
    else $error("vendor code changed after lock");

  io_hit_c: cover property (io_hit);
  svid_lock_c: cover property ($rose(svid_locked));
  table_hit_c: cover property (table_hit);
  aper_hit_c: cover property (aperture_hit && !aperture_size_control[1]);

endmodule
`default_nettype wire

// File: test/gch_host_model.sv
// Host bridge model issuing configuration cycles to the header block
`timescale 1ns/10ps
`default_nettype none
module gch_host_model (
  input  wire logic        mclk,      // System clock
  output logic             cfg_req,   // Access strobe
  output logic             cfg_write, // 1 write, 0 read
  output logic      [7:0]  cfg_addr,  // Byte offset
  output logic      [3:0]  cfg_be,    // Byte enables
  output logic      [31:0] cfg_wdata, // Write data
  input  wire logic        cfg_ack,   // Access done
  input  wire logic [31:0] cfg_rdata  // Read data
);
  // ************************************
  // Idle bus and one access per call
  // ************************************
  initial begin
    cfg_req   = 1'b0;
    cfg_write = 1'b0;
    cfg_addr  = 8'h00;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0;
  end
  // Strobe lasts one cycle; qualifiers stay put until the answer is taken
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d, output logic [31:0] q, output logic ok);
    ok = 1'b0;
    q  = 32'h0;
    @(posedge mclk);
    cfg_req   <= 1'b1;
    cfg_write <= w;
    cfg_addr  <= a;
    cfg_be    <= be;
    cfg_wdata <= d;
    // Bounded wait, a lost answer reports back as not ok
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge mclk);
      cfg_req <= 1'b0;
      #1;
      if (cfg_ack === 1'b1) begin
        ok = 1'b1;
        q  = cfg_rdata;
      end
    end
  endtask
endmodule
`default_nettype wire

// File: test/gch_cfg_bars_tb_top.sv
// Self-checking bench for the configuration header range block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", nm, e, s); end end
module gch_cfg_bars_tb_top
  import gch_pkg::*;
;
  // ************************************
  // Signals, clock and instances
  // ************************************
  logic mclk = 1'b0, reset = 1'b1;               // Clock, reset held at start
  logic cfg_req, cfg_write, cfg_ack;             // Config handshake
  logic [7:0] cfg_addr;                          // Config offset
  logic [3:0] cfg_be;                            // Byte enables
  logic [31:0] cfg_wdata, cfg_rdata;             // Config data
  logic func1_enable = 1'b1, tem = 1'b0;         // Header and trusted levels
  logic [1:0] asc = 2'b00, pm_state = 2'b00;     // Size control, power state
  logic io_enable = 1'b1, device_on = 1'b1, graphics_enable = 1'b1; // I/O gates
  logic [35:0] mem_addr = 36'h0;                 // Decoded address
  logic mem_req = 1'b0, io_req = 1'b0;           // Decode strobes
  logic [15:0] io_addr = 16'h0;                  // I/O address
  logic regs_hit, table_hit, aperture_hit, io_hit, io_refused, svid_locked;
  int n_mismatch = 0, checks = 0;                // Report counters
  // Gate settings {pm, io_en, dev_on, gfx} that must close the window
  localparam logic [4:0] BAD [5] = '{5'h0f, 5'h1f, 5'h03, 5'h05, 5'h06};
  always #10 mclk = ~mclk;
  gch_host_model host (.mclk, .cfg_req, .cfg_write, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_ack, .cfg_rdata);
  gch_cfg_bars dut (.mclk, .reset, .cfg_req, .cfg_write, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_ack, .cfg_rdata, .func1_enable, .aperture_size_control(asc),
    .trusted_execution_mode(tem), .pm_state, .io_enable, .device_on, .graphics_enable,
    .mem_addr, .mem_req, .regs_hit, .table_hit, .aperture_hit, .io_req, .io_addr,
    .io_hit, .io_refused, .svid_locked);
  // ************************************
  // Access tasks and verdict
  // ************************************
  task automatic results();
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // A lost answer counts as a mismatch and ends the run
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d, input logic [31:0] e);
    logic [31:0] q;
    logic        ok;
    host.xfer(w, a, be, d, q, ok);
    if (!ok) begin
      n_mismatch++;
      results();
    end else if (!w) `CHK("cfg_rdata", e, q)
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    acc(1'b1, a, be, d, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 4'h0, 32'h0, e);
  endtask
  // One decode strobe; hits are registered, so look one edge later
  task automatic probe(input logic io, input logic [35:0] a, input logic [4:0] e);
    @(posedge mclk);
    mem_req  <= !io;
    io_req   <= io;
    mem_addr <= a;
    io_addr  <= a[15:0];
    @(posedge mclk);
    mem_req <= 1'b0;
    io_req  <= 1'b0;
    #1;
    `CHK("hits", e, {regs_hit, table_hit, aperture_hit, io_hit, io_refused})
  endtask
  // ************************************
  // Main sequence
  // ************************************
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    wr(SVID_OFS, 4'h3, 32'h5a5a_1234);
    rd(SVID_OFS, 32'h0000_1234);
    wr(SVID_OFS, 4'hf, 32'h0000_beef);
    rd(SVID_OFS, 32'h0000_1234);
    `CHK("svid_locked", 1'b1, svid_locked)
    rd(HDR_TYPE_OFS, {8'h00, 1'b1, HDR_CODE, 16'h0});
    @(posedge mclk);
    func1_enable <= 1'b0;
    wr(HDR_TYPE_OFS, 4'hf, 32'hffff_ffff);
    rd(HDR_TYPE_OFS, 32'h0);
    rd(8'h30, 32'h0);
    wr(MMIO_BASE_OFS, 4'hf, 32'hffff_ffff);
    rd(MMIO_BASE_OFS, MMIO_WMASK_LO | MMIO_FIXED_LO);
    wr(MMIO_BASE_OFS, 4'hf, 32'h0040_0000);
    wr(MMIO_BASE_OFS_HI, 4'hf, 32'h0000_000a);
    rd(MMIO_BASE_OFS_HI, 32'h0000_000a);
    probe(1'b0, 36'ha_0047_ffff, 5'b10000);
    probe(1'b0, 36'ha_0048_0000, 5'b00000);
    probe(1'b0, 36'ha_0060_0000, 5'b01000);
    probe(1'b0, 36'ha_0080_0000, 5'b00000);
    wr(APER_BASE_OFS, 4'hf, 32'hffff_ffff);
    rd(APER_BASE_OFS, 32'hf800_000c);
    for (int i = 1; i < 4; i++) begin
      @(posedge mclk);
      asc <= 2'(i);
      rd(APER_BASE_OFS, (i == 1) ? 32'hf000_000c : 32'he000_000c);
    end
    @(posedge mclk);
    asc <= 2'b00;
    tem <= 1'b1;
    wr(APER_BASE_OFS, 4'hf, 32'h2000_0000);
    rd(APER_BASE_OFS, 32'h3800_000c);
    @(posedge mclk);
    tem <= 1'b0;
    probe(1'b0, 36'h0_2000_0000, 5'b00000);
    probe(1'b0, 36'h0_3800_0000, 5'b00100);
    @(posedge mclk);
    asc <= 2'b10;
    probe(1'b0, 36'h0_3fff_ffff, 5'b00100);
    probe(1'b0, 36'h0_4000_0000, 5'b00000);
    wr(IO_BASE_OFS, 4'hf, 32'hffff_ffff);
    rd(IO_BASE_OFS, IO_WMASK | IO_FIXED);
    wr(IO_BASE_OFS, 4'hf, 32'h0000_1238);
    probe(1'b1, 36'h123f, 5'b00010);
    probe(1'b1, 36'h1240, 5'b00000);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      {pm_state, io_enable, device_on, graphics_enable} <= BAD[i];
      probe(1'b1, 36'h1238, 5'b00001);
    end
    // Second reset in mid-run clears the locked vendor code
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(SVID_OFS, 32'h0);
    `CHK("svid_locked", 1'b0, svid_locked)
    rd(MMIO_BASE_OFS, MMIO_FIXED_LO);
    results();
  end
endmodule
`default_nettype wire
